/* hw/nfc_byte_fifo.sv */
/*
  byte fifo with registered read data and an output stage.
  assumes one clock; flush empties it; out_en gates staging of data.
*/
`timescale 1ns/1ps
`default_nettype none

module nfc_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 512
) (
  input  wire logic                       clk_sys,   // system clock
  input  wire logic                       rst,       // async reset, high
  input  wire logic                       flush,     // drop all content
  input  wire logic                       in_valid,  // write request
  output logic                            in_ready,  // room in memory
  input  wire logic [WIDTH-1:0]           in_data,   // write data
  input  wire logic                       out_en,    // allow staging
  output logic                            out_valid, // staged word valid
  input  wire logic                       out_ready, // staged word taken
  output logic [WIDTH-1:0]                out_data,  // staged word
  output logic [$clog2(DEPTH):0]          level      // words held
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      mcount;
    logic             ov;
    logic [WIDTH-1:0] od;
    logic [AW:0]      lvl;
  } nfc_fifo_state_t;

  nfc_fifo_state_t r_reg, r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             load;

  // ****************************************************************
  // pointers and output stage
  // ****************************************************************
  always_comb begin
    r_next   = r_reg;
    in_ready = (r_reg.mcount != FULL);
    push     = in_valid && in_ready && !flush;
    load     = out_en && !flush && (r_reg.mcount != '0) && (!r_reg.ov || out_ready);
    if (out_ready && r_reg.ov) begin
      r_next.ov = 1'b0;
    end
    if (push) begin
      r_next.wptr = r_reg.wptr + 1'b1;
    end
    if (load) begin
      r_next.rptr = r_reg.rptr + 1'b1;
      r_next.ov   = 1'b1;
      r_next.od   = mem[r_reg.rptr];
    end
    r_next.mcount = r_reg.mcount + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    if (flush) begin
      r_next.wptr   = '0;
      r_next.rptr   = '0;
      r_next.mcount = '0;
      r_next.ov     = 1'b0;
    end
    r_next.lvl = r_next.mcount + {{AW{1'b0}}, r_next.ov};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // memory holds no reset so it maps onto a ram
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[r_reg.wptr] <= in_data;
    end
  end

  assign out_valid = r_reg.ov;
  assign out_data  = r_reg.od;
  assign level     = r_reg.lvl;

endmodule : nfc_fifo_mem

`default_nettype wire

/* hw/nfc_codec_map.svh */
/*
  constants of the nfc frame codec: fifo size, bit timing, crc figures.
  assumes a system clock of 125 mhz; included by package and modules.
*/
`ifndef NFC_CODEC_MAP_SVH
`define NFC_CODEC_MAP_SVH

// ****************************************************************
// fifo
// ****************************************************************
`define NFC_FIFO_DEPTH    512
`define NFC_FIFO_AW       9
`define NFC_TX_LEN_W      13

// ****************************************************************
// bit timing
// ****************************************************************
`define NFC_CLK_MHZ       125
`define NFC_BIT_106_NS    9440
`define NFC_BIT_212_NS    4720
`define NFC_BIT_424_NS    2360
`define NFC_BIT_848_NS    1180
`define NFC_BIT_106_CYC   ((`NFC_BIT_106_NS * `NFC_CLK_MHZ) / 1000)
`define NFC_BIT_212_CYC   ((`NFC_BIT_212_NS * `NFC_CLK_MHZ) / 1000)
`define NFC_BIT_424_CYC   ((`NFC_BIT_424_NS * `NFC_CLK_MHZ) / 1000)
`define NFC_BIT_848_CYC   ((`NFC_BIT_848_NS * `NFC_CLK_MHZ) / 1000)
`define NFC_TMR_W         11

// ****************************************************************
// crc and character layout
// ****************************************************************
`define NFC_CRC_POLY      16'h8408
`define NFC_CRC_PRESET_A  16'h6363
`define NFC_CRC_PRESET_B  16'hffff
`define NFC_CRC_RESID_A   16'h0000
`define NFC_CRC_RESID_B   16'hf0b8
`define NFC_CHAR_A_BITS   4'ha
`define NFC_CHAR_B_BITS   4'h9
`define NFC_CHAR_S_BITS   4'h8
`define NFC_LINE_IDLE     1'b0

`endif

/* hw/nfc_codec_pkg.sv */
/*
  types of the nfc frame codec: modes, states, configuration and status.
  assumes nfc_codec_map.svh sits beside it.
*/
`include "nfc_codec_map.svh"

package nfc_codec_pkg;

  typedef enum logic [1:0] {
    NFC_XFER_FRAMED = 2'h0,
    NFC_XFER_STREAM = 2'h1,
    NFC_XFER_TRANSP = 2'h2
  } nfc_xfer_t;

  typedef enum logic {
    NFC_RF_A = 1'h0,
    NFC_RF_B = 1'h1
  } nfc_rf_t;

  typedef enum logic [1:0] {
    NFC_RATE_106 = 2'h0,
    NFC_RATE_212 = 2'h1,
    NFC_RATE_424 = 2'h2,
    NFC_RATE_848 = 2'h3
  } nfc_rate_t;

  typedef enum logic [2:0] {
    NFC_ST_IDLE  = 3'h0,
    NFC_ST_SOF   = 3'h1,
    NFC_ST_FETCH = 3'h2,
    NFC_ST_TXBIT = 3'h3,
    NFC_ST_EOF   = 3'h4,
    NFC_ST_HUNT  = 3'h5,
    NFC_ST_RXBIT = 3'h6
  } nfc_state_t;

  typedef struct packed {
    logic      pwr_on;
    logic      dir_rx;
    nfc_xfer_t xfer;
    nfc_rf_t   rf;
    nfc_rate_t rate;
    logic      rx_en;
  } nfc_cfg_t;

  typedef struct packed {
    logic tx_busy;
    logic rx_busy;
    logic tx_done;
    logic rx_done;
    logic err_par;
    logic err_crc;
    logic err_under;
    logic err_over;
  } nfc_status_t;

endpackage : nfc_codec_pkg

/* hw/nfc_frame_codec.sv */
/*
  nfc frame codec: tx encoder, rx decoder, shared fifo and link crossing.
  assumes host fifo ports on clk_sys, rf modulator and digitizer on clk_link,
  and serial host pins arriving asynchronously.
*/
// What this block does
// - encoder adds sof, eof, crc, parity per mode
// - framed transmit takes payload from the fifo
// - stream transmit sends fifo bits unframed
// - transparent mode with spi selected: mosi level drives modulation
// - decoder checks framing, keeps crc, strips rest
// - decoded bytes go into the fifo
// - stream receive stores digitized subcarrier in fifo
// - transparent mode: subcarrier drives miso while spi is selected and enabled
// - one 512-byte fifo, direction picks its use
// - transmit up to 8191 bytes, receive unlimited
// - select pin chooses spi or i2c host
// - power-down refuses fifo access, keeps config
`timescale 1ns/1ps
`default_nettype none

module nfc_frame_codec
  import nfc_codec_pkg::*;
(
  input  wire logic                        clk_sys,        // system clock 125 mhz
  input  wire logic                        rst,            // async reset, high
  input  wire logic                        clk_link,       // rf link clock
  input  wire nfc_cfg_t                    cfg,            // mode configuration
  input  wire logic [`NFC_TX_LEN_W-1:0]    tx_len,         // payload bytes to send
  input  wire logic                        tx_start,       // start transmit, pulse
  input  wire logic                        host_wr_valid,  // host fifo write
  output logic                             host_wr_ready,  // fifo accepts write
  input  wire logic [7:0]                  host_wr_data,   // host write byte
  output logic                             host_rd_valid,  // fifo byte ready
  input  wire logic                        host_rd_ready,  // host takes byte
  output logic [7:0]                       host_rd_data,   // fifo read byte
  output logic [`NFC_FIFO_AW:0]            fifo_level,     // bytes in fifo
  output nfc_status_t                      status,         // busy, done, errors
  input  wire logic                        i2c_sel_pin,    // host interface select
  input  wire logic                        spi_sel_n_pin,  // spi enable, low
  input  wire logic                        mosi_pin,       // spi data in
  output logic                             miso_o,         // miso level
  output logic                             miso_oe,        // miso driven
  input  wire logic                        rx_sub_pin,     // digitized subcarrier
  output logic                             tx_mod          // modulation to driver
);

  typedef struct packed {
    nfc_state_t              st;
    logic [`NFC_TMR_W-1:0]   tmr;
    logic [3:0]              nbits;
    logic [10:0]             shift;
    logic [`NFC_TX_LEN_W:0]  bytes;
    logic [15:0]             crc;
    logic                    tx_level;
    logic [1:0]              mosi_s;
    logic [1:0]              i2c_s;
    logic [1:0]              sel_s;
    logic [1:0]              rx_s;
    logic                    rx_q;
    logic                    miso;
    logic                    miso_oe;
    logic                    wr_ready;
    logic                    dir_q;
    nfc_status_t             stat;
  } nfc_core_t;

  typedef struct packed {
    logic [1:0] tx_s;
    logic [1:0] rx_s;
    logic       mod;
  } nfc_link_t;

  nfc_core_t r_reg, r_next;
  nfc_link_t l_reg, l_next;

  logic                    f_in_valid;
  logic                    f_in_ready;
  logic [7:0]              f_in_data;
  logic                    f_out_en;
  logic                    f_out_valid;
  logic                    f_out_ready;
  logic [7:0]              f_out_data;
  logic                    f_flush;
  logic [`NFC_FIFO_AW:0]   f_level;

  logic                    framed;
  logic                    stream;
  logic                    transp;
  logic                    rf_b;
  logic                    spi_mode;
  logic                    host_wr;
  logic [`NFC_TMR_W-1:0]   period;
  logic [15:0]             preset;
  logic [15:0]             resid;
  logic [15:0]             crc_out;
  logic [15:0]             crc_new;
  logic [`NFC_TX_LEN_W:0]  total;
  logic [7:0]              tx_byte;
  logic [3:0]              char_bits;
  logic [10:0]             rx_shift;
  logic [10:0]             rx_char;
  logic                    cont;

  // ****************************************************************
  // crc over one byte, lsb first
  // ****************************************************************
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `NFC_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_byte

  // ****************************************************************
  // shared fifo
  // ****************************************************************
  nfc_fifo_mem #(
    .WIDTH (8),
    .DEPTH (`NFC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (f_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_en    (f_out_en),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // ****************************************************************
  // system domain: codec state machine
  // ****************************************************************
  always_comb begin
    r_next        = r_reg;
    r_next.mosi_s = {r_reg.mosi_s[0], mosi_pin};
    r_next.i2c_s  = {r_reg.i2c_s[0], i2c_sel_pin};
    r_next.sel_s  = {r_reg.sel_s[0], spi_sel_n_pin};
    r_next.rx_s   = {r_reg.rx_s[0], l_reg.rx_s[1]};
    r_next.rx_q   = r_reg.rx_s[1];
    r_next.dir_q  = cfg.dir_rx;
    r_next.stat.tx_done = 1'b0;
    r_next.stat.rx_done = 1'b0;
    r_next.tmr    = (r_reg.tmr != '0) ? r_reg.tmr - 1'b1 : r_reg.tmr;

    framed   = (cfg.xfer == NFC_XFER_FRAMED);
    stream   = (cfg.xfer == NFC_XFER_STREAM);
    transp   = (cfg.xfer == NFC_XFER_TRANSP);
    rf_b     = (cfg.rf == NFC_RF_B);
    spi_mode = !r_reg.i2c_s[1];
    case (cfg.rate)
      NFC_RATE_106: period = `NFC_TMR_W'(`NFC_BIT_106_CYC);
      NFC_RATE_212: period = `NFC_TMR_W'(`NFC_BIT_212_CYC);
      NFC_RATE_424: period = `NFC_TMR_W'(`NFC_BIT_424_CYC);
      default:      period = `NFC_TMR_W'(`NFC_BIT_848_CYC);
    endcase
    preset  = rf_b ? `NFC_CRC_PRESET_B : `NFC_CRC_PRESET_A;
    resid   = rf_b ? `NFC_CRC_RESID_B : `NFC_CRC_RESID_A;
    crc_out = rf_b ? ~r_reg.crc : r_reg.crc;
    total   = {1'b0, tx_len} + (framed ? 14'h0002 : 14'h0000);
    tx_byte = (r_reg.bytes < {1'b0, tx_len}) ? f_out_data :
              ((r_reg.bytes == {1'b0, tx_len}) ? crc_out[7:0] : crc_out[15:8]);
    crc_new = r_reg.crc;
    cont    = (r_reg.bytes + 1'b1) != total;
    char_bits = !framed ? `NFC_CHAR_S_BITS : (rf_b ? `NFC_CHAR_B_BITS : `NFC_CHAR_A_BITS);
    rx_shift  = {r_reg.rx_s[1], r_reg.shift[10:1]};
    rx_char   = rx_shift >> (4'hb - char_bits);

    // fifo side selection; power-down refuses host access, transparent refuses writes and new staging
    host_wr     = host_wr_valid && r_reg.wr_ready;
    f_flush     = (cfg.dir_rx != r_reg.dir_q);
    f_out_en    = cfg.pwr_on && !transp;
    f_in_valid  = cfg.dir_rx ? 1'b0 : host_wr;
    f_in_data   = host_wr_data;
    f_out_ready = cfg.dir_rx ? (host_rd_ready && cfg.pwr_on) : 1'b0;

    r_next.wr_ready = cfg.pwr_on && !cfg.dir_rx && !transp &&
      (({1'b0, f_level} + {{(`NFC_FIFO_AW+1){1'b0}}, f_in_valid}) <
       (`NFC_FIFO_AW+2)'(`NFC_FIFO_DEPTH));

    // transparent path straight between pins and rf line
    r_next.miso    = r_reg.rx_s[1];
    r_next.miso_oe = transp && spi_mode && !r_reg.sel_s[1];

    case (r_reg.st)
      NFC_ST_IDLE: begin
        r_next.tx_level = (transp && spi_mode) ? r_reg.mosi_s[1] : `NFC_LINE_IDLE;
        if (cfg.pwr_on && !transp && !cfg.dir_rx && tx_start) begin
          r_next.bytes = '0;
          r_next.crc   = preset;
          r_next.stat.err_under = 1'b0;
          r_next.stat.tx_busy   = 1'b1;
          r_next.tmr   = period - 1'b1;
          if (framed) begin
            r_next.st       = NFC_ST_SOF;
            r_next.tx_level = 1'b1;
          end else begin
            r_next.st       = NFC_ST_FETCH;
          end
        end else if (cfg.pwr_on && !transp && cfg.dir_rx && cfg.rx_en) begin
          r_next.crc   = preset;
          r_next.nbits = '0;
          r_next.shift = '0;
          r_next.stat.rx_busy = 1'b1;
          r_next.stat.err_par = 1'b0;
          r_next.stat.err_crc = 1'b0;
          r_next.stat.err_over = 1'b0;
          r_next.tmr   = period - 1'b1;
          r_next.st    = framed ? NFC_ST_HUNT : NFC_ST_RXBIT;
        end
      end
      NFC_ST_SOF: begin
        if (r_reg.tmr == '0) begin
          r_next.st = NFC_ST_FETCH;
        end
      end
      NFC_ST_FETCH: begin
        if (r_reg.bytes == total) begin
          r_next.tx_level = `NFC_LINE_IDLE;
          if (framed) begin
            r_next.st  = NFC_ST_EOF;
            r_next.tmr = period - 1'b1;
          end else begin
            r_next.st  = NFC_ST_IDLE;
            r_next.stat.tx_busy = 1'b0;
            r_next.stat.tx_done = 1'b1;
          end
        end else if (r_reg.bytes < {1'b0, tx_len} && !f_out_valid) begin
          r_next.stat.err_under = 1'b1;
        end else begin
          if (r_reg.bytes < {1'b0, tx_len}) begin
            f_out_ready = 1'b1;
            r_next.crc  = crc_byte(r_reg.crc, tx_byte);
          end
          if (!framed) begin
            r_next.shift = {3'b000, tx_byte};
          end else if (rf_b) begin
            r_next.shift = {2'b00, cont, tx_byte};
          end else begin
            r_next.shift = {1'b0, cont, ~^tx_byte, tx_byte};
          end
          r_next.nbits    = char_bits;
          r_next.tx_level = tx_byte[0];
          r_next.tmr      = period - 1'b1;
          r_next.bytes    = r_reg.bytes + 1'b1;
          r_next.st       = NFC_ST_TXBIT;
        end
      end
      NFC_ST_TXBIT: begin
        if (r_reg.tmr == '0) begin
          if (r_reg.nbits == 4'h1) begin
            r_next.st = NFC_ST_FETCH;
          end else begin
            r_next.shift    = r_reg.shift >> 1;
            r_next.tx_level = r_reg.shift[1];
            r_next.nbits    = r_reg.nbits - 1'b1;
            r_next.tmr      = period - 1'b1;
          end
        end
      end
      NFC_ST_EOF: begin
        if (r_reg.tmr == '0) begin
          r_next.st = NFC_ST_IDLE;
          r_next.stat.tx_busy = 1'b0;
          r_next.stat.tx_done = 1'b1;
        end
      end
      NFC_ST_HUNT: begin
        if (!cfg.rx_en || !cfg.pwr_on) begin
          r_next.st = NFC_ST_IDLE;
          r_next.stat.rx_busy = 1'b0;
        end else if (r_reg.rx_s[1] && !r_reg.rx_q) begin
          r_next.tmr   = period + (period >> 1) - 1'b1;
          r_next.nbits = '0;
          r_next.shift = '0;
          r_next.crc   = preset;
          r_next.st    = NFC_ST_RXBIT;
        end
      end
      NFC_ST_RXBIT: begin
        if (!cfg.rx_en || !cfg.pwr_on) begin
          r_next.st = NFC_ST_IDLE;
          r_next.stat.rx_busy = 1'b0;
          r_next.stat.rx_done = stream;
        end else if (r_reg.tmr == '0) begin
          r_next.tmr   = period - 1'b1;
          r_next.shift = rx_shift;
          r_next.nbits = r_reg.nbits + 1'b1;
          if ((r_reg.nbits + 1'b1) == char_bits) begin
            r_next.nbits = '0;
            r_next.shift = '0;
            f_in_valid   = 1'b1;
            f_in_data    = rx_char[7:0];
            if (!f_in_ready) begin
              r_next.stat.err_over = 1'b1;
            end
            if (framed) begin
              crc_new    = crc_byte(r_reg.crc, rx_char[7:0]);
              r_next.crc = crc_new;
              if (!rf_b && (rx_char[8] != ~^rx_char[7:0])) begin
                r_next.stat.err_par = 1'b1;
              end
              if (!(rf_b ? rx_char[8] : rx_char[9])) begin
                r_next.st = NFC_ST_HUNT;
                r_next.stat.rx_done = 1'b1;
                if (crc_new != resid) begin
                  r_next.stat.err_crc = 1'b1;
                end
              end
            end
          end
        end
      end
      default: begin
        r_next.st = NFC_ST_IDLE;
      end
    endcase

    if (!cfg.pwr_on) begin
      r_next.stat.tx_busy = (r_reg.st != NFC_ST_IDLE) ? r_next.stat.tx_busy : 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // link domain: modulation out, subcarrier in
  // ****************************************************************
  always_comb begin
    l_next      = l_reg;
    l_next.tx_s = {l_reg.tx_s[0], r_reg.tx_level};
    l_next.rx_s = {l_reg.rx_s[0], rx_sub_pin};
    l_next.mod  = l_reg.tx_s[1];
  end

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign host_wr_ready = r_reg.wr_ready;
  assign host_rd_valid = f_out_valid;
  assign host_rd_data  = f_out_data;
  assign fifo_level    = f_level;
  assign status        = r_reg.stat;
  assign miso_o        = r_reg.miso;
  assign miso_oe       = r_reg.miso_oe;
  assign tx_mod        = l_reg.mod;

endmodule : nfc_frame_codec

`default_nettype wire

/* verif/nfc_codec_props.sv */
/*
  checker watching the ports of the nfc frame codec.
  assumes the codec package and map header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nfc_codec_map.svh"

module nfc_codec_props
  import nfc_codec_pkg::*;
(
  input wire logic                  clk_sys,       // clock
  input wire logic                  rst,           // reset
  input wire nfc_cfg_t              cfg,           // config
  input wire logic                  tx_start,      // tx pulse
  input wire logic                  host_wr_valid, // write
  input wire logic                  host_wr_ready, // write ok
  input wire logic                  host_rd_valid, // byte staged
  input wire logic                  host_rd_ready, // byte taken
  input wire logic [`NFC_FIFO_AW:0] fifo_level,    // level
  input wire nfc_status_t           status,        // status
  input wire logic                  i2c_sel_pin,   // select
  input wire logic                  miso_oe        // miso enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ****************************************************************
  // assertions
  // ****************************************************************
  pd_wr_block_a: assert property (!$past(cfg.pwr_on) |-> !host_wr_ready)
    else $error("write accepted in power-down");
  rx_wr_block_a: assert property ($past(cfg.dir_rx) |-> !host_wr_ready)
    else $error("write accepted in receive direction");
  transp_wr_block_a: assert property ($past(cfg.xfer) == NFC_XFER_TRANSP |-> !host_wr_ready)
    else $error("fifo write accepted in transparent mode");
  level_step_a: assert property (host_wr_valid && host_wr_ready && !status.tx_busy && !tx_start
    && $stable(cfg) |=> fifo_level == $past(fifo_level) + 1'b1)
    else $error("fifo level did not count a write");
  level_cap_a: assert property (fifo_level <= 10'h200)
    else $error("fifo level above capacity");
  full_refuse_a: assert property (fifo_level == 10'h200 |-> !host_wr_ready)
    else $error("write ready while fifo full");
  busy_start_a: assert property (tx_start && cfg.pwr_on && !cfg.dir_rx && !status.tx_busy
    && cfg.xfer != NFC_XFER_TRANSP |=> status.tx_busy)
    else $error("transmit did not start");
  rd_pop_a: assert property (host_rd_valid && host_rd_ready && cfg.pwr_on && cfg.dir_rx
    && fifo_level == 10'h001 |=> !host_rd_valid)
    else $error("read byte not popped");
  i2c_quiet_a: assert property (i2c_sel_pin [*5] |-> !miso_oe)
    else $error("miso driven while i2c selected");
  full_c: cover property (fifo_level == 10'h200);
  tx_c: cover property (status.tx_done);
  miso_c: cover property (miso_oe);
endmodule : nfc_codec_props

bind nfc_frame_codec nfc_codec_props i_nfc_codec_props (.clk_sys, .rst, .cfg, .tx_start,
  .host_wr_valid, .host_wr_ready, .host_rd_valid, .host_rd_ready, .fifo_level, .status,
  .i2c_sel_pin, .miso_oe);
`default_nettype wire

/* verif/nfc_rf_peer.sv */
/*
  rf far side: digitizer output feeding the codec receive pin.
  assumes clk_link runs free; bit time is 98 link cycles (848 rate).
*/
`timescale 1ns/1ps
`default_nettype none

module nfc_rf_peer (
  input  wire logic clk_link,   // link clock
  output var logic  rx_sub_pin  // digitized subcarrier
);
  initial rx_sub_pin = 1'b0;
  // sends one byte lsb first, line back to idle low afterwards
  task send(input logic [7:0] b);
    for (int k = 0; k < 8; k++) begin
      rx_sub_pin <= b[k];
      repeat (98) @(posedge clk_link);
    end
    rx_sub_pin <= 1'b0;
  endtask : send
endmodule : nfc_rf_peer
`default_nettype wire

/* verif/testbench.sv */
/*
  self-checking bench of the nfc frame codec.
  assumes design, package, checker and rf peer are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import nfc_codec_pkg::*;
  logic        clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, tx_start = 1'b0;
  nfc_cfg_t    cfg = '0;
  logic [12:0] tx_len = 13'h1;
  logic        host_wr_valid = 1'b0, host_rd_ready = 1'b0, i2c_sel_pin = 1'b1;
  logic        spi_sel_n_pin = 1'b1, mosi_pin = 1'b0, host_wr_ready, host_rd_valid;
  logic        miso_o, miso_oe, rx_sub_pin, tx_mod;
  logic [7:0]  host_wr_data = 8'h00, host_rd_data, rb;
  logic [9:0]  fifo_level;
  nfc_status_t status;
  int          fail_count = 0, check_count = 0;
  always #4 clk_sys = ~clk_sys;
  initial #1.3 forever #6 clk_link = ~clk_link;
  nfc_frame_codec i_nfc_frame_codec (.clk_sys, .rst, .clk_link, .cfg, .tx_len, .tx_start,
    .host_wr_valid, .host_wr_ready, .host_wr_data, .host_rd_valid, .host_rd_ready,
    .host_rd_data, .fifo_level, .status, .i2c_sel_pin, .spi_sel_n_pin, .mosi_pin, .miso_o,
    .miso_oe, .rx_sub_pin, .tx_mod);
  nfc_rf_peer i_nfc_rf_peer (.clk_link, .rx_sub_pin);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task results;
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task chk(input string n, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task tmo;
    fail_count++;
    results();
  endtask : tmo
  // leaves valid high so back-to-back writes keep the strobe up
  task wr(input logic [7:0] d);
    host_wr_valid = 1'b1;
    host_wr_data = d;
    for (int i = 0; i <= 100; i++) begin
      if (i == 100) tmo();
      if (host_wr_ready === 1'b1) break;
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
  endtask : wr
  // starts a transmit and compares n bits at mid-bit (147 cycles per bit)
  task tx_bits(input logic [9:0] exp, input int n);
    host_wr_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    tx_start = 1'b1;
    @(negedge clk_sys);
    tx_start = 1'b0;
    repeat (78) @(negedge clk_sys);
    for (int k = 0; k < n; k++) begin
      chk("tx_mod", {9'h0, tx_mod}, {9'h0, exp[k]});
      repeat (147) @(negedge clk_sys);
    end
    for (int i = 0; i <= 20000; i++) begin
      if (i == 20000) tmo();
      if (status.tx_busy === 1'b0) break;
      @(negedge clk_sys);
    end
    chk("tx_status", {8'h00, status.tx_busy, status.err_under}, 10'h000);
  endtask : tx_bits
  // waits for a staged byte, pops it with a one-cycle ready pulse
  task rd(input logic [7:0] e);
    for (int i = 0; i <= 200; i++) begin
      if (i == 200) tmo();
      if (host_rd_valid === 1'b1) break;
      @(negedge clk_sys);
    end
    rb = host_rd_data;
    host_rd_ready = 1'b1;
    @(negedge clk_sys);
    host_rd_ready = 1'b0;
    chk("rd_data", {2'b00, rb}, {2'b00, e});
  endtask : rd
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    cfg.rate = NFC_RATE_848;
    cfg.rf = NFC_RF_B;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("wr_ready_pd", {9'h0, host_wr_ready}, 10'h0);
    cfg.pwr_on = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 512; i++) wr(i[7:0]);
    host_wr_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("level_full", fifo_level, 10'h200);
    chk("wr_ready_full", {9'h0, host_wr_ready}, 10'h0);
    cfg.dir_rx = 1'b1;
    repeat (3) @(negedge clk_sys);
    cfg.dir_rx = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("level_flush", fifo_level, 10'h0);
    cfg.xfer = NFC_XFER_STREAM;
    wr(8'ha5);
    tx_bits({2'b00, 8'ha5}, 8);
    cfg.xfer = NFC_XFER_FRAMED;
    wr(8'h5a);
    tx_bits({1'b1, 8'h5a, 1'b1}, 10);
    cfg.dir_rx = 1'b1;
    cfg.xfer = NFC_XFER_STREAM;
    repeat (3) @(negedge clk_sys);
    cfg.rx_en = 1'b1;
    i_nfc_rf_peer.send(8'h3c);
    repeat (4) @(negedge clk_sys);
    cfg.rx_en = 1'b0;
    rd(8'h3c);
    cfg.xfer = NFC_XFER_FRAMED;
    cfg.rx_en = 1'b1;
    repeat (3) @(negedge clk_sys);
    // sof, eight data ones, continue bit zero; one byte cannot carry a good crc
    i_nfc_rf_peer.send(8'hff);
    i_nfc_rf_peer.send(8'h01);
    @(negedge clk_sys);
    chk("rx_framed_status", {2'b00, status}, 10'h044);
    rd(8'hff);
    cfg.rx_en = 1'b0;
    cfg.xfer = NFC_XFER_TRANSP;
    i2c_sel_pin = 1'b0;
    spi_sel_n_pin = 1'b0;
    mosi_pin = 1'b1;
    i_nfc_rf_peer.rx_sub_pin = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("tx_mod_hi", {9'h0, tx_mod}, 10'h1);
    chk("miso_hi", {8'h0, miso_oe, miso_o}, 10'h3);
    mosi_pin = 1'b0;
    i_nfc_rf_peer.rx_sub_pin = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("tx_mod_lo", {9'h0, tx_mod}, 10'h0);
    chk("miso_lo", {8'h0, miso_oe, miso_o}, 10'h2);
    i2c_sel_pin = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("miso_oe_i2c", {9'h0, miso_oe}, 10'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
